// file: rtl/ddrsp_pkg.sv
// Shared constants for the two-word burst DDR SRAM port and its controller.
// Assumes one 200 MHz core clock on both ends; link pins are plain flops.
package ddrsp_pkg;

  localparam int ADDR_W        = 20;
  localparam int LANE_W        = 9;
  localparam int LANES         = 2;
  localparam int DATA_W        = LANE_W * LANES;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int DLL_STOP_NS   = 30;
  // Least time, so round up
  localparam int DLL_STOP_CYC  = (DLL_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLL_LOCK_CYC  = 1024;
  localparam int ZQ_CAL_CYC    = 1024;

  // Host side: read word capture offsets from the command cycle
  localparam int RD_W0_LAT     = 4;
  localparam int RD_W1_LAT     = 5;
  localparam int TURN_NOPS     = 2;
  localparam int BUF_DEPTH     = 2;

  typedef enum logic [1:0] {
    DDRSP_NOP,
    DDRSP_READ,
    DDRSP_WRITE
  } ddrsp_cmd_e;

endpackage

// file: rtl/ddrsp_if.sv
// Link between the burst SRAM port and its controller.
// Shared data pins are resolved here from the two output enables.
`timescale 1ns/1ps
interface ddrsp_if #(
  parameter int ADDR_W = ddrsp_pkg::ADDR_W,
  parameter int LANES  = ddrsp_pkg::LANES,
  parameter int DATA_W = ddrsp_pkg::DATA_W
);
  logic              k_pos;
  logic              k_neg;
  logic              c_pos;
  logic              c_neg;
  logic              load_strobe_n;
  logic              read_not_write;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  byte_lane_write_select_n;
  logic              dll_disable_pin;
  logic [DATA_W-1:0] host_dq;
  logic              host_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] dq;
  logic              echo_clock_pos;
  logic              echo_clock_neg;

  // Device wins on contention; idle bus reads zero
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

  modport device (
    input  k_pos, k_neg, c_pos, c_neg, load_strobe_n, read_not_write, addr,
    input  byte_lane_write_select_n, dll_disable_pin, dq,
    output dev_dq, dev_dq_oe, echo_clock_pos, echo_clock_neg
  );

  modport host (
    output k_pos, k_neg, c_pos, c_neg, load_strobe_n, read_not_write, addr,
    output byte_lane_write_select_n, dll_disable_pin, host_dq, host_dq_oe,
    input  dq, echo_clock_pos, echo_clock_neg
  );
endinterface

// file: rtl/ddrsp_device.sv
// Burst SRAM device end: array, posted write, read bypass, echo clocks,
// DLL lock status and impedance recalibration tick.
// Assumes link pins change on core_clk edges and are sampled synchronously.
`timescale 1ns/1ps

// Summary of operation
// [R1] Output clocks high at power-on select single-clock
// [R2] Single-clock strap latched once, then frozen
// [R3] Controller puts one NOP before read-to-write
// [R4] Controller may add second turnaround NOP
// [R5] Write following read is held in registers
// [R6] Held write committed at next write command
// [R7] Read of pending address returns pending data
// [R8] Controller gives each bank its own strobe; this controller drives one load_strobe_n for the whole device
// [R9] Output impedance recalibrated every 1024 cycles
// [R10] Echo clocks follow output clocks, free running
// [R11] Single-clock mode echoes the input clocks
// [R12] DLL locks after 1024 stable input cycles
// [R13] Input clock stopped 30 ns resets DLL
// [R14] DLL disable pin low disables DLL
// [R15] Write words at K and K# of t+1
// [R16] Read words at C# t+1, C t+2
// [R17] Low lane select writes lane, high keeps
// [R18] All selects high writes nothing that half
// [R19] Second burst address has LSB inverted
// [R20] Deselect finishes reads, then outputs float
// [R21] Powers up deselected with outputs off
// [R22] Bypass merges written lanes with array lanes
module ddrsp_device #(
  parameter int ADDR_W       = ddrsp_pkg::ADDR_W,
  parameter int LANE_W       = ddrsp_pkg::LANE_W,
  parameter int LANES        = ddrsp_pkg::LANES,
  parameter int DLL_LOCK_CYC = ddrsp_pkg::DLL_LOCK_CYC,
  parameter int ZQ_CAL_CYC   = ddrsp_pkg::ZQ_CAL_CYC
) (
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  ddrsp_if.device    link,
  output logic       single_clock_mode,
  output logic       dll_locked,
  output logic       impedance_update
);

  localparam int DATA_W = LANE_W * LANES;
  localparam int LCK_W  = $clog2(DLL_LOCK_CYC + 1);
  localparam int ZQ_W   = $clog2(ZQ_CAL_CYC);
  localparam int STP_W  = $clog2(ddrsp_pkg::DLL_STOP_CYC + 1);
  localparam logic [LCK_W-1:0] LOCK_MAX = LCK_W'(DLL_LOCK_CYC);
  localparam logic [ZQ_W-1:0]  ZQ_LAST  = ZQ_W'(ZQ_CAL_CYC - 1);
  localparam logic [STP_W-1:0] STOP_MAX = STP_W'(ddrsp_pkg::DLL_STOP_CYC);

  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

  logic              strap_done;
  logic              k_pos_q;
  logic              k_neg_q;
  logic              oc_pos_q;
  logic              oc_neg_q;
  logic              wr_arm;
  logic [ADDR_W-1:0] wr_arm_addr;
  logic              wr_w1;
  logic [ADDR_W-1:0] col_addr;
  logic [DATA_W-1:0] col_d0;
  logic [LANES-1:0]  col_m0;
  logic              pend_valid;
  logic [ADDR_W-1:0] pend_addr;
  logic [DATA_W-1:0] pend_d0;
  logic [DATA_W-1:0] pend_d1;
  logic [LANES-1:0]  pend_m0;
  logic [LANES-1:0]  pend_m1;
  logic              rd_arm;
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_go;
  logic [ADDR_W-1:0] rd_go_addr;
  logic              rd_w1;
  logic [ADDR_W-1:0] rd_w1_addr;
  logic [LCK_W-1:0]  lock_cnt;
  logic [STP_W-1:0]  stop_cnt;
  logic [ZQ_W-1:0]   zq_cnt;

  // Edge detection of the link clocks
  wire oc_pos      = single_clock_mode ? link.k_pos : link.c_pos; // R1
  wire oc_neg      = single_clock_mode ? link.k_neg : link.c_neg; // R1
  wire k_rise      = link.k_pos & ~k_pos_q;
  wire kn_rise     = link.k_neg & ~k_neg_q;
  wire oc_pos_rise = oc_pos & ~oc_pos_q;
  wire oc_neg_rise = oc_neg & ~oc_neg_q;

  // Commands are ignored until the strap is known
  wire cmd_valid = k_rise & ~link.load_strobe_n & strap_done;
  wire rd_cmd    = cmd_valid & link.read_not_write;
  wire wr_cmd    = cmd_valid & ~link.read_not_write;

  wire cap_w0    = k_rise & wr_arm; // R15
  wire cap_w1    = kn_rise & wr_w1; // R15
  wire commit    = pend_valid & (wr_cmd | cap_w1); // R6
  wire rd_load0  = oc_neg_rise & rd_go; // R16
  wire rd_load1  = oc_pos_rise & rd_w1; // R16
  wire rd_busy   = rd_arm | rd_go | rd_w1;

  wire [ADDR_W-1:0] pend_addr1 = pend_addr ^ ADDR_W'(1); // R19
  wire [ADDR_W-1:0] rd_sel     = rd_load1 ? rd_w1_addr : rd_go_addr;
  wire              hit0       = pend_valid & (pend_addr == rd_sel); // R7
  wire              hit1       = pend_valid & (pend_addr1 == rd_sel); // R7
  wire [DATA_W-1:0] arr_rd     = mem[rd_sel];
  wire [DATA_W-1:0] arr_c0     = mem[pend_addr];
  wire [DATA_W-1:0] arr_c1     = mem[pend_addr1];
  wire              en_c0      = ~&pend_m0; // R18
  wire              en_c1      = ~&pend_m1; // R18

  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] cm_w0;
  logic [DATA_W-1:0] cm_w1;

  // Per-lane merge for commit and for bypassed reads
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    assign cm_w0[l*LANE_W +: LANE_W] = pend_m0[l] ? arr_c0[l*LANE_W +: LANE_W]
                                                  : pend_d0[l*LANE_W +: LANE_W]; // R17
    assign cm_w1[l*LANE_W +: LANE_W] = pend_m1[l] ? arr_c1[l*LANE_W +: LANE_W]
                                                  : pend_d1[l*LANE_W +: LANE_W]; // R17
    assign rd_word[l*LANE_W +: LANE_W] =
      (hit0 & ~pend_m0[l]) ? pend_d0[l*LANE_W +: LANE_W] :
      (hit1 & ~pend_m1[l]) ? pend_d1[l*LANE_W +: LANE_W] :
      arr_rd[l*LANE_W +: LANE_W]; // R22
  end

  // Strap caught once at the first edge after reset release
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_done        <= 1'b0;
      single_clock_mode <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done        <= 1'b1;
      single_clock_mode <= link.c_pos & link.c_neg; // R2
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      k_pos_q  <= 1'b0;
      k_neg_q  <= 1'b0;
      oc_pos_q <= 1'b0;
      oc_neg_q <= 1'b0;
    end
    else
    begin
      k_pos_q  <= link.k_pos;
      k_neg_q  <= link.k_neg;
      oc_pos_q <= oc_pos;
      oc_neg_q <= oc_neg;
    end
  end

  // Write burst collection; the finished burst is always posted
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_arm      <= 1'b0;
      wr_arm_addr <= '0;
      wr_w1       <= 1'b0;
      col_addr    <= '0;
      col_d0      <= '0;
      col_m0      <= '1;
    end
    else
    begin
      if (k_rise)
        wr_arm <= wr_cmd;
      if (wr_cmd)
        wr_arm_addr <= link.addr;
      if (cap_w0)
      begin
        col_addr <= wr_arm_addr;
        col_d0   <= link.dq;
        col_m0   <= link.byte_lane_write_select_n;
      end
      if (cap_w0)
        wr_w1 <= 1'b1;
      else if (cap_w1)
        wr_w1 <= 1'b0;
    end
  end

  // Posted write registers stay put across any run of reads
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_valid <= 1'b0;
      pend_addr  <= '0;
      pend_d0    <= '0;
      pend_d1    <= '0;
      pend_m0    <= '1;
      pend_m1    <= '1;
    end
    else if (cap_w1)
    begin
      pend_valid <= 1'b1; // R5
      pend_addr  <= col_addr;
      pend_d0    <= col_d0;
      pend_m0    <= col_m0;
      pend_d1    <= link.dq;
      pend_m1    <= link.byte_lane_write_select_n;
    end
    else if (commit)
      pend_valid <= 1'b0; // R6
  end

  // Array has no reset; contents are undefined at power-up
  always_ff @(posedge core_clk)
  begin
    if (commit & en_c0)
      mem[pend_addr] <= cm_w0; // R17
    if (commit & en_c1)
      mem[pend_addr1] <= cm_w1; // R19
  end

  // Read pipeline and output drivers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_arm     <= 1'b0;
      rd_addr    <= '0;
      rd_go      <= 1'b0;
      rd_go_addr <= '0;
      rd_w1      <= 1'b0;
      rd_w1_addr <= '0;
    end
    else
    begin
      if (k_rise)
        rd_arm <= rd_cmd;
      if (rd_cmd)
        rd_addr <= link.addr;
      if (k_rise & rd_arm)
        rd_go_addr <= rd_addr;
      if (k_rise & rd_arm)
        rd_go <= 1'b1;
      else if (rd_load0)
        rd_go <= 1'b0;
      if (rd_load0)
      begin
        rd_w1      <= 1'b1;
        rd_w1_addr <= rd_go_addr ^ ADDR_W'(1); // R19
      end
      else if (rd_load1)
        rd_w1 <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.dev_dq    <= '0;
      link.dev_dq_oe <= 1'b0; // R21
    end
    else
    begin
      if (rd_load0 | rd_load1)
        link.dev_dq <= rd_word; // R16
      if (rd_load0)
        link.dev_dq_oe <= 1'b1;
      else if (oc_pos_rise & ~rd_load1 & ~rd_busy)
        link.dev_dq_oe <= 1'b0; // R20
    end
  end

  // Free-running echoes, one core cycle behind the output clocks
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.echo_clock_pos <= 1'b0;
      link.echo_clock_neg <= 1'b0;
    end
    else
    begin
      link.echo_clock_pos <= oc_pos; // R10 R11
      link.echo_clock_neg <= oc_neg; // R10 R11
    end
  end

  // DLL lock model: counts input rises, restarts on a stopped clock
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stop_cnt   <= '0;
      lock_cnt   <= '0;
      dll_locked <= 1'b0;
    end
    else
    begin
      if (k_rise)
        stop_cnt <= '0;
      else if (stop_cnt != STOP_MAX)
        stop_cnt <= stop_cnt + STP_W'(1);
      if (!link.dll_disable_pin)
      begin
        lock_cnt   <= '0; // R14
        dll_locked <= 1'b0;
      end
      else if (stop_cnt == STOP_MAX)
      begin
        lock_cnt   <= '0; // R13
        dll_locked <= 1'b0;
      end
      else if (k_rise & (lock_cnt != LOCK_MAX))
      begin
        lock_cnt   <= lock_cnt + LCK_W'(1); // R12
        dll_locked <= (lock_cnt == LOCK_MAX - LCK_W'(1));
      end
    end
  end

  // Recalibration tick; the analog update itself lives outside
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zq_cnt           <= '0;
      impedance_update <= 1'b0;
    end
    else
    begin
      zq_cnt           <= (zq_cnt == ZQ_LAST) ? '0 : zq_cnt + ZQ_W'(1);
      impedance_update <= (zq_cnt == ZQ_LAST); // R9
    end
  end

endmodule

// file: rtl/ddrsp_host.sv
// Controller end: makes the input clocks, issues commands on slots,
// drives write bursts and buffers returned read bursts.
// Assumes the device end shares core_clk; one link cycle is two core cycles.
`timescale 1ns/1ps
module ddrsp_host #(
  parameter int   ADDR_W       = ddrsp_pkg::ADDR_W,
  parameter int   LANES        = ddrsp_pkg::LANES,
  parameter int   DATA_W       = ddrsp_pkg::DATA_W,
  parameter int   TURN_NOPS    = ddrsp_pkg::TURN_NOPS,
  parameter bit   SINGLE_CLOCK = 1'b0,
  parameter bit   DLL_ENABLE   = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  ddrsp_if.host                  link,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata0,
  input  wire logic [DATA_W-1:0] cmd_wdata1,
  input  wire logic [LANES-1:0]  cmd_wsel0_n,
  input  wire logic [LANES-1:0]  cmd_wsel1_n,
  output logic                   cmd_ready_rd,
  output logic                   cmd_ready_wr,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [2*DATA_W-1:0]    rd_data
);

  localparam int OWE_W = $clog2(TURN_NOPS + 1);

  logic [OWE_W-1:0]    nop_owed;
  logic                wq_v;
  logic [DATA_W-1:0]   wq_d0;
  logic [DATA_W-1:0]   wq_d1;
  logic [LANES-1:0]    wq_s0;
  logic [LANES-1:0]    wq_s1;
  logic                hold_v;
  logic [DATA_W-1:0]   hold_d;
  logic [LANES-1:0]    hold_s;
  logic [ddrsp_pkg::RD_W1_LAT:0] rd_pipe;
  logic [DATA_W-1:0]   cap_w0;
  logic [1:0]          inflight;
  logic                skid_v;
  logic [2*DATA_W-1:0] skid_d;

  // Slot cycle: k_pos low now, high next
  wire slot     = ~link.k_pos;
  wire take_rd  = slot & cmd_valid & ~cmd_write & cmd_ready_rd;
  wire take_wr  = slot & cmd_valid & cmd_write & cmd_ready_wr;
  wire push     = rd_pipe[ddrsp_pkg::RD_W1_LAT];
  wire pop      = rd_valid & rd_ready;
  wire [1:0] used = 2'(rd_valid) + 2'(skid_v) + inflight;
  wire [2*DATA_W-1:0] push_d = {link.dq, cap_w0};

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.k_pos           <= 1'b0;
      link.k_neg           <= 1'b1;
      link.c_pos           <= SINGLE_CLOCK;
      link.c_neg           <= 1'b1;
      link.dll_disable_pin <= DLL_ENABLE;
    end
    else
    begin
      link.k_pos <= ~link.k_pos;
      link.k_neg <= link.k_pos;
      link.c_pos <= SINGLE_CLOCK | ~link.k_pos;
      link.c_neg <= SINGLE_CLOCK | link.k_pos;
    end
  end

  // Command slots and read-to-write turnaround
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.load_strobe_n  <= 1'b1;
      link.read_not_write <= 1'b1;
      link.addr           <= '0;
      nop_owed            <= '0;
      cmd_ready_rd        <= 1'b0;
      cmd_ready_wr        <= 1'b0;
    end
    else if (slot)
    begin
      link.load_strobe_n <= ~(take_rd | take_wr);
      if (take_rd | take_wr)
      begin
        link.read_not_write <= take_rd;
        link.addr           <= cmd_addr;
      end
      if (take_rd)
        nop_owed <= OWE_W'(TURN_NOPS); // R3 R4
      else if (nop_owed != '0)
        nop_owed <= nop_owed - OWE_W'(1);
      cmd_ready_rd <= 1'b0;
      cmd_ready_wr <= 1'b0;
    end
    else
    begin
      cmd_ready_rd <= (used < 2'(ddrsp_pkg::BUF_DEPTH));
      cmd_ready_wr <= (nop_owed == '0); // R3
    end
  end

  // Write data: word0 at next K rise, word1 at the K# rise after
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wq_v    <= 1'b0;
      wq_d0   <= '0;
      wq_d1   <= '0;
      wq_s0   <= '1;
      wq_s1   <= '1;
      hold_v  <= 1'b0;
      hold_d  <= '0;
      hold_s  <= '1;
      link.host_dq    <= '0;
      link.host_dq_oe <= 1'b0;
      link.byte_lane_write_select_n <= '1;
    end
    else if (slot)
    begin
      wq_v <= take_wr;
      if (take_wr)
      begin
        wq_d0 <= cmd_wdata0;
        wq_d1 <= cmd_wdata1;
        wq_s0 <= cmd_wsel0_n;
        wq_s1 <= cmd_wsel1_n;
      end
      hold_v          <= wq_v;
      hold_d          <= wq_d1;
      hold_s          <= wq_s1;
      link.host_dq_oe <= wq_v; // R15
      link.host_dq    <= wq_d0;
      link.byte_lane_write_select_n <= wq_v ? wq_s0 : '1;
    end
    else
    begin
      hold_v          <= 1'b0;
      link.host_dq_oe <= hold_v; // R15
      link.host_dq    <= hold_d;
      link.byte_lane_write_select_n <= hold_v ? hold_s : '1;
    end
  end

  // Read capture at fixed latency, then a two-entry skid buffer
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pipe  <= '0;
      cap_w0   <= '0;
      inflight <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      skid_v   <= 1'b0;
      skid_d   <= '0;
    end
    else
    begin
      rd_pipe <= {rd_pipe[ddrsp_pkg::RD_W1_LAT-1:0], take_rd};
      if (rd_pipe[ddrsp_pkg::RD_W0_LAT])
        cap_w0 <= link.dq; // R16
      inflight <= inflight + 2'(take_rd) - 2'(push);
      if (pop | ~rd_valid)
      begin
        rd_valid <= skid_v | push;
        rd_data  <= skid_v ? skid_d : push_d;
        skid_v   <= skid_v & push;
        skid_d   <= push_d;
      end
      else if (push)
      begin
        skid_v <= 1'b1;
        skid_d <= push_d;
      end
    end
  end

endmodule

// file: dv/ddrsp_props.sv
// Concurrent checks on the link between the two burst SRAM port ends.
// Assumes one core clock; sees link signals and the device status pins.
`timescale 1ns/1ps
module ddrsp_props #(
  parameter int DLL_LOCK_CYC = 8,
  parameter int ZQ_CAL_CYC   = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic k_pos,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic echo_clock_pos,
  input wire logic echo_clock_neg,
  input wire logic dll_locked,
  input wire logic impedance_update
);
  logic        k_q;
  logic [3:0]  since_rd;
  logic [11:0] krise_cnt;
  logic [11:0] zq_gap;
  logic        zq_seen;
  wire         k_rise = k_pos & ~k_q;
  wire         rd_cmd = k_rise & ~load_strobe_n & read_not_write;
  wire         wr_cmd = k_rise & ~load_strobe_n & ~read_not_write;

  // Saturating, so idle stretches never wrap into a false window
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      k_q       <= 1'b0;
      since_rd  <= 4'hF;
      krise_cnt <= 12'h000;
    end
    else
    begin
      k_q       <= k_pos;
      since_rd  <= rd_cmd ? 4'h1 : (since_rd == 4'hF ? since_rd : since_rd + 4'h1);
      krise_cnt <= (k_rise && krise_cnt != 12'hFFF) ? krise_cnt + 12'h001 : krise_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zq_gap  <= 12'h000;
      zq_seen <= 1'b0;
    end
    else if (impedance_update)
    begin
      zq_gap  <= 12'h001;
      zq_seen <= 1'b1;
    end
    else if (zq_gap != 12'hFFF)
      zq_gap <= zq_gap + 12'h001;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_cmd;
    rd_cmd;
  endsequence
  sequence s_wr_cmd;
    wr_cmd;
  endsequence
  sequence s_write_data;
    host_dq_oe ##1 host_dq_oe;
  endsequence

  a_read_oe_window: assert property (s_rd_cmd |-> ##4 dev_dq_oe [*3])
    else $error("read burst not driven in its window");
  a_read_float: assert property ($fell(dev_dq_oe) |-> since_rd == 4'h7)
    else $error("data outputs released at wrong time");
  a_idle_float: assert property (since_rd == 4'hF |-> !dev_dq_oe)
    else $error("data outputs driven with no read");
  a_write_data: assert property (s_wr_cmd |-> ##2 s_write_data)
    else $error("write words not driven at t+1");
  a_turnaround: assert property (s_rd_cmd |-> ##2 !wr_cmd ##2 !wr_cmd)
    else $error("write too soon after read");
  a_bus_clash: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drive the data bus");
  a_echo_pair: assert property ($rose(echo_clock_pos) |=>
    $rose(echo_clock_neg) && !echo_clock_pos ##1 echo_clock_pos)
    else $error("echo clocks not complementary");
  a_echo_run: assert property (!echo_clock_pos |-> ##[1:3] echo_clock_pos)
    else $error("echo clock stopped");
  a_lock_count: assert property ($rose(dll_locked) |-> krise_cnt == DLL_LOCK_CYC)
    else $error("lock after wrong number of input clocks");
  a_zq_period: assert property (zq_seen |->
    (impedance_update == (zq_gap == ZQ_CAL_CYC)) && zq_gap <= ZQ_CAL_CYC)
    else $error("impedance update period wrong");
endmodule

// file: dv/ddr_two_word_burst_sram_port_tb.sv
// Self-checking bench: two port pairs, normal and single-clock strap.
// Assumes both pairs see the same user traffic; counts shortened to 8.
`timescale 1ns/1ps
module ddr_two_word_burst_sram_port_tb;
  localparam int AW   = ddrsp_pkg::ADDR_W;
  localparam int DW   = ddrsp_pkg::DATA_W;
  localparam int LW   = ddrsp_pkg::LANE_W;
  localparam int LOCK = 8;
  localparam int ZQ   = 8;

  logic              core_clk   = 1'b0;
  logic              rst_b      = 1'b0;
  logic              cmd_valid  = 1'b0;
  logic              cmd_write  = 1'b0;
  logic [AW-1:0]     cmd_addr   = '0;
  logic [DW-1:0]     cmd_wdata0 = '0;
  logic [DW-1:0]     cmd_wdata1 = '0;
  logic [1:0]        cmd_wsel0_n = 2'h3;
  logic [1:0]        cmd_wsel1_n = 2'h3;
  logic              rd_ready   = 1'b0;
  logic              cmd_ready_rd;
  logic              cmd_ready_wr;
  logic              rd_valid;
  logic [2*DW-1:0]   rd_data;
  logic [2*DW-1:0]   rd_data_sc;
  logic              scm;
  logic              scm_sc;
  logic              locked;
  logic              zq_upd;
  logic              ok;
  int                failures = 0;
  int                checks   = 0;
  logic [DW-1:0]     mem [logic [AW-1:0]];

  always #2.5 core_clk = ~core_clk;

  ddrsp_if u_ddrsp_if ();
  ddrsp_if u_ddrsp_if_sc ();

  ddrsp_device #(.DLL_LOCK_CYC(LOCK), .ZQ_CAL_CYC(ZQ)) u_ddrsp_device (
    .core_clk(core_clk), .rst_b(rst_b), .link(u_ddrsp_if),
    .single_clock_mode(scm), .dll_locked(locked), .impedance_update(zq_upd));
  ddrsp_host u_ddrsp_host (
    .core_clk(core_clk), .rst_b(rst_b), .link(u_ddrsp_if), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0),
    .cmd_wdata1(cmd_wdata1), .cmd_wsel0_n(cmd_wsel0_n), .cmd_wsel1_n(cmd_wsel1_n),
    .cmd_ready_rd(cmd_ready_rd), .cmd_ready_wr(cmd_ready_wr), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  ddrsp_device #(.DLL_LOCK_CYC(LOCK), .ZQ_CAL_CYC(ZQ)) u_ddrsp_device_sc (
    .core_clk(core_clk), .rst_b(rst_b), .link(u_ddrsp_if_sc),
    .single_clock_mode(scm_sc), .dll_locked(), .impedance_update());
  ddrsp_host #(.SINGLE_CLOCK(1'b1)) u_ddrsp_host_sc (
    .core_clk(core_clk), .rst_b(rst_b), .link(u_ddrsp_if_sc), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0),
    .cmd_wdata1(cmd_wdata1), .cmd_wsel0_n(cmd_wsel0_n), .cmd_wsel1_n(cmd_wsel1_n),
    .cmd_ready_rd(), .cmd_ready_wr(), .rd_valid(), .rd_ready(rd_ready),
    .rd_data(rd_data_sc));

  ddrsp_props #(.DLL_LOCK_CYC(LOCK), .ZQ_CAL_CYC(ZQ)) u_ddrsp_props (
    .core_clk(core_clk), .rst_b(rst_b), .k_pos(u_ddrsp_if.k_pos),
    .load_strobe_n(u_ddrsp_if.load_strobe_n), .read_not_write(u_ddrsp_if.read_not_write),
    .host_dq_oe(u_ddrsp_if.host_dq_oe), .dev_dq_oe(u_ddrsp_if.dev_dq_oe),
    .echo_clock_pos(u_ddrsp_if.echo_clock_pos), .echo_clock_neg(u_ddrsp_if.echo_clock_neg),
    .dll_locked(locked), .impedance_update(zq_upd));

  task automatic check(input string what, input logic [2*DW-1:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the command until taken or lim edges pass; model tracks taken writes
  task automatic send(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                      input logic [1:0] s0, s1, input int lim, output logic taken);
    int            n;
    logic [AW-1:0] ai;
    cmd_valid   <= 1'b1;
    cmd_write   <= wr;
    cmd_addr    <= a;
    cmd_wdata0  <= d0;
    cmd_wdata1  <= d1;
    cmd_wsel0_n <= s0;
    cmd_wsel1_n <= s1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while ((wr ? cmd_ready_wr : cmd_ready_rd) !== 1'b1 && n < lim);
    taken = ((wr ? cmd_ready_wr : cmd_ready_rd) === 1'b1);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 2 && taken && wr; i++)
    begin
      ai = {a[AW-1:1], a[0] ^ i[0]};
      for (int l = 0; l < 2; l++)
        if (!(i ? s1[l] : s0[l]))
          mem[ai][l*LW +: LW] = i ? d1[l*LW +: LW] : d0[l*LW +: LW];
    end
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1, input logic [1:0] s0, s1);
    send(1'b1, a, d0, d1, s0, s1, 40, ok);
    check("write_taken", ok, 1'b1);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    send(1'b0, a, '0, '0, 2'h3, 2'h3, 40, ok);
    check("read_taken", ok, 1'b1);
  endtask

  task automatic collect(input logic [AW-1:0] a);
    int n;
    rd_ready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rd_valid !== 1'b1 && n < 40);
    rd_ready <= 1'b0;
    check("rd_data", rd_data, {mem[{a[AW-1:1], ~a[0]}], mem[a]});
    check("rd_data_sc", rd_data_sc, {mem[{a[AW-1:1], ~a[0]}], mem[a]});
  endtask

  task automatic t_reset();
    check("dq_oe_idle", u_ddrsp_if.dev_dq_oe, 1'b0);
    check("strap", scm, 1'b0);
    check("strap_sc", scm_sc, 1'b1);
  endtask

  // Read straight after a write hits the posted burst
  task automatic t_bypass();
    wr(20'h00011, 18'h3A5A5, 18'h0C3C3, 2'h0, 2'h0);
    rd(20'h00011);
    collect(20'h00011);
  endtask

  task automatic t_lanes();
    wr(20'h00020, 18'h15555, 18'h2AAAA, 2'h0, 2'h0);
    wr(20'h00020, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h3);
    rd(20'h00020);
    collect(20'h00020);
    wr(20'h00031, 18'h01234, 18'h2BCDE, 2'h1, 2'h0);
    rd(20'h00020);
    collect(20'h00020);
    rd(20'h00031);
    collect(20'h00031);
  endtask

  // Receiver stalls: two bursts held, third read refused, none lost
  task automatic t_stall();
    rd(20'h00011);
    rd(20'h00020);
    send(1'b0, 20'h00031, '0, '0, 2'h3, 2'h3, 30, ok);
    check("read_refused", ok, 1'b0);
    collect(20'h00011);
    collect(20'h00020);
    rd(20'h00031);
    collect(20'h00031);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_bypass();
    t_lanes();
    t_stall();
    repeat (20) @(posedge core_clk);
    check("strap_kept", scm_sc, 1'b1);
    check("dll_locked", locked, 1'b1);
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    failures++;
    test_done();
  end
endmodule
